// File: rtl/ext_bus_defs.svh
// Offsets, field positions, reset values and vector addresses of the
// external bus and interrupt pin block.
// Assumes a 32-bit register port with byte addresses on 8 bits.
`ifndef EXT_BUS_DEFS_SVH
`define EXT_BUS_DEFS_SVH

// Register offsets
`define OFS_BANK 8'h00
`define OFS_WAIT 8'h04
`define OFS_IMASK 8'h08
`define OFS_IFLAG 8'h0C
`define OFS_GMASK 8'h10
`define OFS_EVT_STAT 8'h14
`define OFS_EVT_CLR 8'h18
`define OFS_EVT_EN 8'h1C
`define OFS_ACC_ADDR 8'h20
`define OFS_ACC_DATA 8'h24
`define OFS_ACC_CMD 8'h28
`define OFS_BUS_STAT 8'h2C

// Field positions
`define BANK_KEEP_BIT 0
`define CMD_WRITE_BIT 0
`define CMD_SPACE_LO 1
`define EVT_DONE_BIT 0
`define EVT_NMI_BIT 1
`define EVT_INT_BIT 2

// Reset values
`define RST_WAIT 3'h2
`define RST_GMASK 1'b1
`define RST_SYNC 8'hFF

// Ready is only checked from this many software wait states upward
`define READY_MIN_WS 3'h2

// Vector locations in program space
`define VEC_NMI 20'h0FF88
`define VEC_INT_BASE 20'h0FFC0

// Positions inside the synchronised pin vector
`define SYN_READY 0
`define SYN_HOLD 1
`define SYN_OFF 2
`define SYN_NMI 3
`define SYN_IRQ_LO 4

`endif

// File: rtl/ext_bus_pkg.sv
// Types shared by the external bus block.
// Assumes nothing beyond a SystemVerilog compiler.
package ext_bus_pkg;

  // Bus sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_STROBE = 4'b0010,
    ST_FINISH = 4'b0100,
    ST_HELD = 4'b1000
  } bus_state_e;

  // Address space codes of an access command
  typedef enum logic [1:0] {
    SP_DATA = 2'h0,
    SP_PROG = 2'h1,
    SP_IO = 2'h2
  } space_e;

endpackage

// File: rtl/sync_if.sv
// Carries raw pin levels into the synchroniser and clean levels back.
// Assumes one clock domain, clk_sys.
interface sync_if;
  logic [7:0] raw;
  logic [7:0] clean;
  modport src (output raw, input clean);
  modport snk (input raw, output clean);
endinterface

// File: rtl/pin_sync.sv
// Three-stage synchroniser with agreement filter for the input pins.
// Assumes pins change slowly against clk_sys; all rest high.
`include "ext_bus_defs.svh"

module pin_sync (
  input wire logic clk_sys,
  input wire logic reset,
  sync_if.snk pins
);

  logic [7:0] stage1;
  logic [7:0] stage2;
  logic [7:0] stage3;
  logic [7:0] clean;

  ////////////////////////////////////////////////////////////////////////
  // Stage1 feeds only stage2, keeping metastability out of logic
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stage1 <= `RST_SYNC;
      stage2 <= `RST_SYNC;
      stage3 <= `RST_SYNC;
    end else begin
      stage1 <= pins.raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Per bit, a change counts once stage2 and stage3 agree
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_filt
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          clean[i] <= 1'b1;
        end else if (stage2[i] == stage3[i]) begin
          clean[i] <= stage3[i];
        end
      end
    end
  endgenerate

  assign pins.clean = clean;

endmodule

// File: rtl/ext_bus_pins.sv
// External parallel bus pins and external interrupt inputs.
// Assumes a simple register port master; pads resolve each output and
// its enable, and the keeper drive, into the real wire.
//
// Chosen here: the plain strobed port and the register addresses.
`include "ext_bus_defs.svh"

module ext_bus_pins (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [19:0] address_bus,
  output logic address_oe,
  input wire logic [15:0] data_bus_in,
  output logic [15:0] data_bus_out,
  output logic data_bus_oe,
  output logic keeper_drive,
  output logic [15:0] keeper_level,
  output logic data_space_sel_n,
  output logic program_space_sel_n,
  output logic io_space_sel_n,
  output logic memory_strobe_n,
  output logic rw_dir,
  output logic control_oe,
  input wire logic ready,
  input wire logic hold_req_n,
  output logic hold_ack_n,
  input wire logic off_n,
  output logic interrupt_ack_out,
  output logic interrupt_ack_oe,
  input wire logic [3:0] ext_irq_lines,
  input wire logic nmi_n,
  output logic irq
);

  ext_bus_pkg::bus_state_e state;
  ext_bus_pkg::bus_state_e next_state;
  logic bus_keeper_enable;
  logic [2:0] wait_states;
  logic [3:0] interrupt_mask_reg;
  logic [3:0] interrupt_flag_reg;
  logic global_interrupt_mask;
  logic [2:0] evt_stat;
  logic [2:0] evt_en;
  logic [19:0] acc_addr;
  logic [15:0] acc_data;
  logic acc_write;
  ext_bus_pkg::space_e acc_space;
  logic cmd_pend;
  logic nmi_pend;
  logic cur_write;
  logic cur_vec;
  logic [2:0] wait_cnt;
  logic [3:0] irq_prev;
  logic nmi_prev;
  sync_if pins ();

  ////////////////////////////////////////////////////////////////////////
  // Pin inputs cross into clk_sys
  assign pins.raw = {ext_irq_lines, nmi_n, off_n, hold_req_n, ready};

  pin_sync u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .pins(pins)
  );

  wire ready_ok = pins.clean[`SYN_READY];
  wire hold_req = !pins.clean[`SYN_HOLD];
  wire off_ok = pins.clean[`SYN_OFF];
  wire nmi_level = pins.clean[`SYN_NMI];
  wire [3:0] irq_level = pins.clean[`SYN_IRQ_LO +: 4];

  ////////////////////////////////////////////////////////////////////////
  // Lowest pending index wins; index zero is the most urgent
  function automatic logic [1:0] first_pending(input logic [3:0] req);
    logic [1:0] idx;
    idx = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      if (req[k]) begin
        idx = k[1:0];
      end
    end
    return idx;
  endfunction

  // Falling edges of the active-low request pins
  wire [3:0] irq_fall = irq_prev & ~irq_level;
  wire nmi_fall = nmi_prev & !nmi_level;

  // Requests and take decisions
  wire [3:0] int_ready = interrupt_flag_reg & interrupt_mask_reg &
                         {4{!global_interrupt_mask}};
  wire can_start = (state == ext_bus_pkg::ST_IDLE) && !hold_req;
  wire take_nmi = can_start && nmi_pend;
  wire take_int = can_start && !nmi_pend && (|int_ready);
  wire take_cmd = can_start && !nmi_pend && !(|int_ready) && cmd_pend;
  wire starting = take_nmi || take_int || take_cmd;
  wire [1:0] int_idx = first_pending(int_ready);
  wire [3:0] int_clr = take_int ? (4'h1 << int_idx) : 4'h0;

  // Vector or command address; non-program spaces keep A19..A16 low
  wire [19:0] int_vec = `VEC_INT_BASE + {16'h0000, int_idx, 2'b00};
  wire [19:0] vec_addr = take_nmi ? `VEC_NMI : int_vec;
  wire [19:0] cmd_addr = (acc_space == ext_bus_pkg::SP_PROG) ? acc_addr :
                         {4'h0, acc_addr[15:0]};
  wire [19:0] next_addr = (take_nmi || take_int) ? vec_addr : cmd_addr;
  wire vec_fetch = take_nmi || take_int;
  wire next_write = take_cmd && acc_write;
  wire [1:0] next_space = vec_fetch ? ext_bus_pkg::SP_PROG : acc_space;

  // Ready is honoured only once enough software waits are set
  wire use_ready = wait_states >= `READY_MIN_WS;
  wire strobe_done = (wait_cnt == 3'h0) && (!use_ready || ready_ok);

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: one access from start to finish, or hold granted
  always_comb begin
    next_state = state;
    unique case (state)
      ext_bus_pkg::ST_IDLE: begin
        if (hold_req) begin
          next_state = ext_bus_pkg::ST_HELD;
        end else if (starting) begin
          next_state = ext_bus_pkg::ST_STROBE;
        end
      end
      ext_bus_pkg::ST_STROBE: begin
        if (strobe_done) begin
          next_state = ext_bus_pkg::ST_FINISH;
        end
      end
      ext_bus_pkg::ST_FINISH: begin
        next_state = ext_bus_pkg::ST_IDLE;
      end
      ext_bus_pkg::ST_HELD: begin
        if (!hold_req) begin
          next_state = ext_bus_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // Next pin levels derive from the next state so outputs stay registered
  wire next_active = next_state == ext_bus_pkg::ST_STROBE;
  wire next_wr = next_active && (starting ? next_write : cur_write);
  wire next_vec = next_active && (starting ? vec_fetch : cur_vec);
  wire [1:0] sel_space = starting ? next_space : 2'(address_space_code());
  wire next_data_oe = next_wr && off_ok && !hold_req;

  function automatic logic [1:0] address_space_code();
    return !program_space_sel_n ? ext_bus_pkg::SP_PROG :
           !io_space_sel_n ? ext_bus_pkg::SP_IO : ext_bus_pkg::SP_DATA;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= ext_bus_pkg::ST_IDLE;
      wait_cnt <= 3'h0;
      cur_write <= 1'b0;
      cur_vec <= 1'b0;
      address_bus <= 20'h00000;
      data_bus_out <= 16'h0000;
    end else begin
      state <= next_state;
      wait_cnt <= starting ? wait_states : (wait_cnt != 3'h0 ? wait_cnt - 3'h1 : 3'h0);
      cur_write <= starting ? next_write : cur_write;
      cur_vec <= starting ? vec_fetch : cur_vec;
      address_bus <= starting ? next_addr : address_bus;
      data_bus_out <= starting ? acc_data : data_bus_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drivers; reset floats everything the off input governs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      data_bus_oe <= 1'b0;
      address_oe <= 1'b0;
      control_oe <= 1'b0;
      interrupt_ack_oe <= 1'b0;
      data_space_sel_n <= 1'b1;
      program_space_sel_n <= 1'b1;
      io_space_sel_n <= 1'b1;
      memory_strobe_n <= 1'b1;
      rw_dir <= 1'b1;
      interrupt_ack_out <= 1'b1;
      hold_ack_n <= 1'b1;
    end else begin
      data_bus_oe <= next_data_oe;
      address_oe <= off_ok && next_state != ext_bus_pkg::ST_HELD;
      control_oe <= off_ok && next_state != ext_bus_pkg::ST_HELD;
      interrupt_ack_oe <= off_ok;
      data_space_sel_n <= !(next_active && sel_space == ext_bus_pkg::SP_DATA);
      program_space_sel_n <= !(next_active && sel_space == ext_bus_pkg::SP_PROG);
      io_space_sel_n <= !(next_active && sel_space == ext_bus_pkg::SP_IO);
      memory_strobe_n <= !(next_active && sel_space != ext_bus_pkg::SP_IO);
      rw_dir <= !next_wr;
      interrupt_ack_out <= !next_vec;
      hold_ack_n <= next_state != ext_bus_pkg::ST_HELD;
    end
  end

  // Keeper holds the last level seen; the pad weakly drives it back
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      keeper_drive <= 1'b0;
      keeper_level <= 16'h0000;
    end else begin
      keeper_drive <= bus_keeper_enable && !next_data_oe;
      keeper_level <= data_bus_oe ? data_bus_out : data_bus_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register port decode
  wire wr_bank = reg_wr && reg_addr == `OFS_BANK;
  wire wr_wait = reg_wr && reg_addr == `OFS_WAIT;
  wire wr_imask = reg_wr && reg_addr == `OFS_IMASK;
  wire wr_iflag = reg_wr && reg_addr == `OFS_IFLAG;
  wire wr_gmask = reg_wr && reg_addr == `OFS_GMASK;
  wire wr_eclr = reg_wr && reg_addr == `OFS_EVT_CLR;
  wire wr_een = reg_wr && reg_addr == `OFS_EVT_EN;
  wire wr_aaddr = reg_wr && reg_addr == `OFS_ACC_ADDR;
  wire wr_adata = reg_wr && reg_addr == `OFS_ACC_DATA;
  wire wr_acmd = reg_wr && reg_addr == `OFS_ACC_CMD;
  wire [3:0] sw_flag_clr = wr_iflag ? reg_wdata[3:0] : 4'h0;
  wire read_done = (state == ext_bus_pkg::ST_STROBE) && strobe_done && !cur_write;
  wire [2:0] evt_set;
  assign evt_set[`EVT_DONE_BIT] = next_state == ext_bus_pkg::ST_FINISH;
  assign evt_set[`EVT_NMI_BIT] = take_nmi;
  assign evt_set[`EVT_INT_BIT] = take_int;
  wire [2:0] evt_clr = wr_eclr ? reg_wdata[2:0] : 3'h0;

  // Interrupt latching; a new edge beats a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_prev <= 4'hF;
      nmi_prev <= 1'b1;
      interrupt_flag_reg <= 4'h0;
      nmi_pend <= 1'b0;
    end else begin
      irq_prev <= irq_level;
      nmi_prev <= nmi_level;
      interrupt_flag_reg <= (interrupt_flag_reg & ~int_clr & ~sw_flag_clr) | irq_fall;
      nmi_pend <= (nmi_pend && !take_nmi) || nmi_fall;
    end
  end

  // Read mux; unmapped offsets and write-only registers read zero
  wire [31:0] next_rdata =
    reg_addr == `OFS_BANK ? {31'h0, bus_keeper_enable} :
    reg_addr == `OFS_WAIT ? {29'h0, wait_states} :
    reg_addr == `OFS_IMASK ? {28'h0, interrupt_mask_reg} :
    reg_addr == `OFS_IFLAG ? {28'h0, interrupt_flag_reg} :
    reg_addr == `OFS_GMASK ? {31'h0, global_interrupt_mask} :
    reg_addr == `OFS_EVT_STAT ? {29'h0, evt_stat} :
    reg_addr == `OFS_EVT_EN ? {29'h0, evt_en} :
    reg_addr == `OFS_ACC_ADDR ? {12'h0, acc_addr} :
    reg_addr == `OFS_ACC_DATA ? {16'h0, acc_data} :
    reg_addr == `OFS_BUS_STAT ?
      {28'h0, nmi_pend, !hold_ack_n, cmd_pend, state != ext_bus_pkg::ST_IDLE} :
    32'h0;

  // Software registers; a new command is refused while one is pending
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bus_keeper_enable <= 1'b0;
      wait_states <= `RST_WAIT;
      interrupt_mask_reg <= 4'h0;
      global_interrupt_mask <= `RST_GMASK;
      evt_en <= 3'h0;
      acc_addr <= 20'h00000;
      acc_write <= 1'b0;
      acc_space <= ext_bus_pkg::SP_DATA;
      cmd_pend <= 1'b0;
    end else begin
      bus_keeper_enable <= wr_bank ? reg_wdata[`BANK_KEEP_BIT] : bus_keeper_enable;
      wait_states <= wr_wait ? reg_wdata[2:0] : wait_states;
      interrupt_mask_reg <= wr_imask ? reg_wdata[3:0] : interrupt_mask_reg;
      // Taking a maskable interrupt closes the global mask, as a core would
      global_interrupt_mask <= take_int || (wr_gmask ? reg_wdata[0] : global_interrupt_mask);
      evt_en <= wr_een ? reg_wdata[2:0] : evt_en;
      acc_addr <= wr_aaddr ? reg_wdata[19:0] : acc_addr;
      acc_write <= (wr_acmd && !cmd_pend) ? reg_wdata[`CMD_WRITE_BIT] : acc_write;
      acc_space <= (wr_acmd && !cmd_pend) ?
        ext_bus_pkg::space_e'(reg_wdata[`CMD_SPACE_LO +: 2]) : acc_space;
      cmd_pend <= (cmd_pend && !take_cmd) || (wr_acmd && !cmd_pend);
    end
  end

  // Read data, data latch and event status with interrupt line
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= 32'h0;
      acc_data <= 16'h0000;
      evt_stat <= 3'h0;
      irq <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 32'h0;
      acc_data <= read_done ? data_bus_in : (wr_adata ? reg_wdata[15:0] : acc_data);
      evt_stat <= (evt_stat & ~evt_clr) | evt_set;
      irq <= |(((evt_stat & ~evt_clr) | evt_set) & evt_en);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks on the pin behaviour
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  data_drive_a: assert property (data_bus_oe |-> state == ext_bus_pkg::ST_STROBE && !rw_dir)
    else $error("data bus driven outside a write");
  off_float_a: assert property ($fell(off_ok) |=> !data_bus_oe && !address_oe)
    else $error("bus still driven after off went low");
  ack_off_a: assert property (!off_ok |=> !interrupt_ack_oe)
    else $error("acknowledge driven while off is low");
  held_float_a: assert property (state == ext_bus_pkg::ST_HELD |-> !address_oe)
    else $error("address driven in hold mode");
  high_addr_a: assert property (state == ext_bus_pkg::ST_STROBE && program_space_sel_n
    |-> address_bus[19:16] == 4'h0)
    else $error("upper address used outside program space");
  sel_idle_a: assert property (state != ext_bus_pkg::ST_STROBE
    |-> data_space_sel_n && program_space_sel_n && io_space_sel_n)
    else $error("space select low without valid address");
  strobe_space_a: assert property (!memory_strobe_n |-> io_space_sel_n)
    else $error("memory strobe during an I/O access");
  vec_fetch_a: assert property (take_nmi |=> !interrupt_ack_out && !program_space_sel_n
    && address_bus == `VEC_NMI)
    else $error("non-maskable vector fetch not seen");
  ready_wait_a: assert property (state == ext_bus_pkg::ST_STROBE && wait_cnt == 3'h0
    && use_ready && !ready_ok |=> state == ext_bus_pkg::ST_STROBE)
    else $error("access ended while ready was low");
  int_gate_a: assert property (take_int |-> !global_interrupt_mask && !nmi_pend
    && (interrupt_flag_reg & interrupt_mask_reg) != 4'h0)
    else $error("masked interrupt taken");
  flag_latch_a: assert property (irq_fall[0] |=> interrupt_flag_reg[0])
    else $error("interrupt edge not latched");
  dir_write_a: assert property (!rw_dir |-> cur_write && state == ext_bus_pkg::ST_STROBE)
    else $error("direction low outside a write");
  keep_reset_a: assert property (@(posedge clk_sys) disable iff (1'b0)
    reset |=> !keeper_drive)
    else $error("keeper active after reset");

  write_seen_c: cover property (take_cmd && acc_write ##[1:12] state == ext_bus_pkg::ST_FINISH);
  vec_seen_c: cover property (take_int ##1 !interrupt_ack_out);
  hold_seen_c: cover property (state == ext_bus_pkg::ST_HELD);

endmodule

// File: tb/ext_mem_model.sv
// Behavioural external memory and I/O device on the far side of the bus.
// Assumes one clock; selects, strobe and direction come from the block.
module ext_mem_model (
  input wire logic clk_sys,
  input wire logic [19:0] address_bus,
  input wire logic [15:0] data_bus_out,
  input wire logic data_bus_oe,
  input wire logic keeper_drive,
  input wire logic [15:0] keeper_level,
  input wire logic [2:0] sel_n,
  input wire logic memory_strobe_n,
  input wire logic rw_dir,
  input wire logic interrupt_ack_out,
  input wire logic slow,
  input wire logic [7:0] stall,
  input wire logic [15:0] rd_value,
  output logic ready,
  output logic [15:0] data_bus_in,
  output logic [41:0] seen,
  output logic [7:0] seen_len,
  output logic [7:0] seen_count
);
  logic [7:0] run = 8'h00;
  logic [15:0] last = 16'h0000;
  wire logic sel_any = ~&sel_n;
  wire logic answer = sel_any & rw_dir;

  ////////////////////////////////////////////////////////////////////////
  // Slow device keeps ready low until stall cycles of select pass
  assign ready = ~(slow & (run < stall));
  // Wire level: block, device answer, keeper, else drifting garbage
  assign data_bus_in = data_bus_oe ? data_bus_out : answer ? rd_value :
    keeper_drive ? keeper_level : ~last;

  initial begin
    seen_count = 8'h00;
    seen_len = 8'h00;
  end

  // First select cycle is recorded; length is counted for wait checks
  always @(posedge clk_sys) begin
    last <= data_bus_in;
    if (sel_any) begin
      run <= run + 8'h01;
      if (run == 8'h00) begin
        seen <= {interrupt_ack_out, memory_strobe_n, rw_dir, sel_n, address_bus,
          data_bus_oe ? data_bus_out : 16'h0000};
        seen_count <= seen_count + 8'h01;
      end
    end else if (run != 8'h00) begin
      seen_len <= run;
      run <= 8'h00;
    end
  end
endmodule

// File: tb/tb_ext_bus_pins.sv
// Bench for the external bus pin block: register port, pins, interrupts.
// Assumes the design files and the memory model are compiled before it.
`include "ext_bus_defs.svh"
module tb_ext_bus_pins;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0;
  logic reset = 1'h1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'h0, reg_rd = 1'h0, slow = 1'h0;
  logic hold_req_n = 1'h1, off_n = 1'h1, nmi_n = 1'h1;
  logic [3:0] ext_irq_lines = 4'hF;
  logic [15:0] rd_value = 16'h0, data_bus_in, data_bus_out, keeper_level, last_d;
  logic [31:0] reg_rdata;
  logic [19:0] address_bus;
  logic address_oe, data_bus_oe, keeper_drive, data_space_sel_n, program_space_sel_n;
  logic io_space_sel_n, memory_strobe_n, rw_dir, control_oe, ready, hold_ack_n;
  logic interrupt_ack_out, interrupt_ack_oe, irq;
  logic [41:0] seen;
  logic [7:0] seen_len, seen_count;
  logic [41:0] exp_q [$];
  int fails = 0, total_checks = 0;
  logic [7:0] ofs [4] = '{`OFS_BANK, `OFS_WAIT, `OFS_GMASK, 8'h30};
  logic [31:0] rst_val [4] = '{32'h0, 32'h2, 32'h1, 32'h0};
  wire logic [2:0] sel_n_all = {io_space_sel_n, program_space_sel_n, data_space_sel_n};

  ext_bus_pins uut (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .address_bus, .address_oe, .data_bus_in, .data_bus_out, .data_bus_oe,
    .keeper_drive, .keeper_level, .data_space_sel_n, .program_space_sel_n,
    .io_space_sel_n, .memory_strobe_n, .rw_dir, .control_oe, .ready, .hold_req_n,
    .hold_ack_n, .off_n, .interrupt_ack_out, .interrupt_ack_oe, .ext_irq_lines,
    .nmi_n, .irq);
  ext_mem_model mem (.clk_sys, .address_bus, .data_bus_out, .data_bus_oe,
    .keeper_drive, .keeper_level, .sel_n(sel_n_all), .memory_strobe_n, .rw_dir,
    .interrupt_ack_out, .slow, .stall(8'h0C), .rd_value, .ready, .data_bus_in,
    .seen, .seen_len, .seen_count);

  ////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    final_report();
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: seen %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Register cycles; two idle edges after a write so registered effects settle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 v = reg_rdata;
    @(posedge clk_sys);
  endtask

  // Bounded wait until a new access has been seen and has ended
  task automatic wait_acc(input logic [7:0] n);
    for (int i = 0; i < 400 && (seen_count == n || sel_n_all != 3'h7); i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(seen_count != n, 1'h1);
    @(posedge clk_sys);
  endtask

  // Queue model: expected first cycle of the access, then the compare
  task automatic acc(input logic [1:0] sp, input logic w, input logic drv);
    logic [19:0] a;
    logic [7:0] n;
    logic [31:0] v;
    a = 20'($urandom);
    last_d = 16'($urandom);
    rd_value <= 16'($urandom);
    wr(`OFS_ACC_ADDR, {12'h000, a});
    wr(`OFS_ACC_DATA, {16'h0000, last_d});
    n = seen_count;
    exp_q.push_back({1'h1, sp == 2'h2, ~w, ~(3'h1 << sp),
      sp == 2'h1 ? a : {4'h0, a[15:0]}, (w & drv) ? last_d : 16'h0000});
    wr(`OFS_ACC_CMD, {29'h0, sp, w});
    wait_acc(n);
    chk(seen, exp_q.pop_front());
    rd(`OFS_ACC_DATA, v);
    if (!w) chk(v[15:0], rd_value);
  endtask

  function automatic logic [41:0] vec(input logic [19:0] a);
    return {1'h0, 1'h0, 1'h1, 3'h5, a, 16'h0000};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int r;
    logic [31:0] v;
    logic [7:0] n;
    r = $urandom(93);
    repeat (2) @(posedge clk_sys);
    reset <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      rd(ofs[i], v);
      chk(v, rst_val[i]);
    end
    chk({keeper_drive, sel_n_all, memory_strobe_n, rw_dir}, 6'h1F);
    // All spaces, both directions
    for (int i = 0; i < 6; i++) acc(2'(i % 3), i < 3, 1'h1);
    // Wait states with a prompt and a slow device
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_WAIT, 32'(i / 2));
      slow <= i[0];
      acc(2'h1, i[1], 1'h1);
      if (i < 4 || !i[0]) chk(seen_len, i / 2 + 1);
      else chk(seen_len >= 12 && seen_len <= 20, 1'h1);
    end
    slow <= 1'h0;
    // Keepers follow the last written word, then switch off again
    wr(`OFS_BANK, 32'h1);
    acc(2'h0, 1'h1, 1'h1);
    chk({keeper_drive, keeper_level}, {1'h1, last_d});
    wr(`OFS_BANK, 32'h0);
    chk(keeper_drive, 1'h0);
    // Hold: pins float and a command waits until the bus returns
    hold_req_n <= 1'h0;
    repeat (10) @(posedge clk_sys);
    fork
      acc(2'h1, 1'h1, 1'h1);
      begin
        repeat (30) @(posedge clk_sys);
        chk({address_oe, data_bus_oe, control_oe, hold_ack_n}, 4'h0);
        chk(sel_n_all, 3'h7);
        hold_req_n <= 1'h1;
      end
    join
    // Off input floats everything while the access still runs
    off_n <= 1'h0;
    repeat (10) @(posedge clk_sys);
    chk({address_oe, data_bus_oe, control_oe, interrupt_ack_oe}, 4'h0);
    acc(2'h0, 1'h1, 1'h0);
    off_n <= 1'h1;
    // Two requests at once: lower index first, global mask holds the other
    wr(`OFS_EVT_EN, 32'h7);
    wr(`OFS_IMASK, 32'hF);
    n = seen_count;
    wr(`OFS_GMASK, 32'h0);
    ext_irq_lines <= 4'h9;
    wait_acc(n);
    chk(seen, vec(`VEC_INT_BASE + 20'h4));
    repeat (20) @(posedge clk_sys);
    chk(seen_count, n + 8'h1);
    chk(irq, 1'h1);
    n = seen_count;
    wr(`OFS_GMASK, 32'h0);
    wait_acc(n);
    chk(seen, vec(`VEC_INT_BASE + 20'h8));
    ext_irq_lines <= 4'hF;
    // Non-maskable request passes both masks; masked line only flags
    wr(`OFS_IMASK, 32'h0);
    n = seen_count;
    nmi_n <= 1'h0;
    ext_irq_lines <= 4'hE;
    wait_acc(n);
    chk(seen, vec(`VEC_NMI));
    nmi_n <= 1'h1;
    ext_irq_lines <= 4'hF;
    repeat (20) @(posedge clk_sys);
    chk(seen_count, n + 8'h1);
    rd(`OFS_IFLAG, v);
    chk(v, 32'h1);
    wr(`OFS_IFLAG, 32'h1);
    rd(`OFS_IFLAG, v);
    chk(v, 32'h0);
    // Event status, enable and clear behind the level output
    rd(`OFS_EVT_STAT, v);
    chk(v, 32'h7);
    wr(`OFS_EVT_EN, 32'h0);
    chk(irq, 1'h0);
    wr(`OFS_EVT_EN, 32'h2);
    chk(irq, 1'h1);
    wr(`OFS_EVT_CLR, 32'h2);
    chk(irq, 1'h0);
    rd(`OFS_EVT_STAT, v);
    chk(v, 32'h5);
    final_report();
  end
endmodule
